// file: hw/dpcw_pkg.sv
// package for the drive-profile command/state word block
// assumes a single 100 MHz clock domain and synchronous active-high reset
package dpcw_pkg;
    // ==========================================
    // command word bit positions
    localparam int CMD_PRESET_LSB = 0;
    localparam int CMD_PRESET_MSB = 1;
    localparam int CMD_RAMP_EN    = 2;
    localparam int CMD_NO_COAST   = 3;
    localparam int CMD_NO_QSTOP   = 4;
    localparam int CMD_USE_RAMP   = 5;
    localparam int CMD_START      = 6;
    localparam int CMD_RESET      = 7;
    localparam int CMD_JOG        = 8;
    localparam int CMD_RAMP2      = 9;
    localparam int CMD_VALID      = 10;
    localparam int CMD_RELAY1     = 11;
    localparam int CMD_RELAY2     = 12;
    localparam int CMD_SETUP2     = 13;
    localparam int CMD_REVERSE    = 15;
    // ==========================================
    // state word bit positions
    localparam int ST_CTRL_READY  = 0;
    localparam int ST_DRV_READY   = 1;
    localparam int ST_ENABLE      = 2;
    localparam int ST_TRIP        = 3;
    localparam int ST_ERROR       = 4;
    localparam int ST_TRIPLOCK    = 6;
    localparam int ST_WARNING     = 7;
    localparam int ST_AT_REF      = 8;
    localparam int ST_BUS_CTRL    = 9;
    localparam int ST_FREQ_OK     = 10;
    localparam int ST_IN_OP       = 11;
    localparam int ST_AUTO_START  = 12;
    localparam int ST_VOLT_EXC    = 13;
    localparam int ST_CURR_EXC    = 14;
    localparam int ST_THERM_EXC   = 15;
    // ==========================================
    // configuration option codes
    localparam logic [7:0] RELAY1_OPT      = 8'h24;
    localparam logic [7:0] RELAY2_OPT      = 8'h25;
    localparam logic [3:0] SETUP_MULTI_OPT = 4'h9;
    localparam logic [1:0] REV_SRC_DIGITAL = 2'h0;
    localparam logic [1:0] REV_SRC_BUS     = 2'h1;
    localparam logic [1:0] REV_SRC_OR      = 2'h2;
    localparam logic [1:0] REV_SRC_AND     = 2'h3;
    localparam logic [15:0] CMD_RESET_VAL  = 16'h0000;
    localparam logic [15:0] ST_RESET_VAL   = 16'h0000;
    localparam logic signed [15:0] REF_FULL_SCALE = 16'sh4000;

    typedef enum logic [2:0] {
        DPCW_STOP_NONE  = 3'b000,
        DPCW_STOP_COAST = 3'b001,
        DPCW_STOP_DCBRK = 3'b010,
        DPCW_STOP_QUICK = 3'b011,
        DPCW_STOP_RAMP  = 3'b100
    } dpcw_stop_t;

    typedef struct packed {
        logic [1:0] preset_sel;
        dpcw_stop_t stop_mode;
        logic       output_enable;
        logic       freeze;
        logic       jog;
        logic       ramp2;
        logic       relay1;
        logic       relay2;
        logic       setup2;
        logic       reverse;
        logic       trip_reset;
    } dpcw_cmd_t;

    typedef struct packed {
        logic ctrl_ready;
        logic drv_ready;
        logic tripped;
        logic error;
        logic triplock;
        logic warning;
        logic at_ref;
        logic bus_ctrl;
        logic freq_ok;
        logic running;
        logic auto_stop;
        logic volt_exc;
        logic curr_exc;
        logic therm_exc;
    } dpcw_flags_t;

    typedef struct packed {
        logic [7:0] relay1_func;
        logic [7:0] relay2_func;
        logic [3:0] active_setup;
        logic [1:0] rev_src;
    } dpcw_cfg_t;
endpackage

// file: hw/dpcw_core.sv
// command word decoder and state word assembler for the drive profile
// assumes word writes arrive as a one-cycle strobe with data, flags are synchronous
// Behaviour
// - bits 1:0 pick one of four preset references
// - bit 2 low commands dc brake then stop, high ramps
// - bit 3 low disables output so motor coasts at once
// - bit 4 low requests quick stop on quick-stop ramp
// - bit 5 low freezes output frequency; only speed up/down inputs move it
// - while frozen only coast, dc brake or input stops act
// - bit 6 low ramps down to stop, high permits start
// - trip reset only on rising edge of bit 7
// - bit 8 high selects jog speed
// - bit 9 selects ramp set 1 or 2
// - whole word ignored unless bit 10 is high
// - relays follow bits 11, 12 only with relay options 36, 37
// - bit 13 selects set-up only under multi set-up option 9
// - bit 15 reverses only when reverse source is bus, or, and
// - state bit 0 set when controls ready, clear on trip
// - state bit 1 set when ready though coast active
// - state bit 2 low while coasting, high when start enabled
// - bits 3, 4, 6 report trip, error, triplock
// - state bit 5 has no function, reads zero
// - state bit 7 reports any warning
// - state bit 8 reports speed at reference
// - state bit 9 reports bus control allowed
// - state bit 11 reports start held without coast
// - bits 13, 14, 15 flag voltage, current, thermal limits
// - reference words are signed, 4000 hex is full scale
module dpcw_core (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  cmd_wr,
    input  wire logic [15:0]           drive_command_word,
    input  wire logic signed [15:0]    speed_ref_word,
    input  wire dpcw_pkg::dpcw_cfg_t   cfg,
    input  wire dpcw_pkg::dpcw_flags_t flags,
    input  wire logic                  din_stop,
    input  wire logic                  din_reverse,
    input  wire logic                  din_speed_up,
    input  wire logic                  din_speed_down,
    input  wire logic signed [15:0]    actual_freq_in,
    output logic [15:0]                drive_state_word,
    output logic signed [15:0]         actual_output_frequency_word,
    output logic signed [15:0]         speed_ref_reg,
    output dpcw_pkg::dpcw_cmd_t        cmd_reg,
    output logic                       stop_accepted_reg,
    output logic                       freq_step_up_reg,
    output logic                       freq_step_down_reg
);
    // ==========================================
    // command word latch
    logic [15:0] word_reg;
    logic        reset_bit_reg;
    logic        valid_wr;

    assign valid_wr = cmd_wr && drive_command_word[dpcw_pkg::CMD_VALID];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            word_reg      <= dpcw_pkg::CMD_RESET_VAL;
            speed_ref_reg <= 16'sh0000;
        end else if (valid_wr) begin
            // bit 14 kept but never decoded
            word_reg      <= drive_command_word;
            speed_ref_reg <= speed_ref_word;
        end
    end

    // ==========================================
    // stop mode decode, coast has top priority
    function automatic dpcw_pkg::dpcw_stop_t stop_of(input logic [15:0] w);
        if (!w[dpcw_pkg::CMD_NO_COAST]) begin
            stop_of = dpcw_pkg::DPCW_STOP_COAST;
        end else if (!w[dpcw_pkg::CMD_RAMP_EN]) begin
            stop_of = dpcw_pkg::DPCW_STOP_DCBRK;
        end else if (!w[dpcw_pkg::CMD_NO_QSTOP]) begin
            stop_of = dpcw_pkg::DPCW_STOP_QUICK;
        end else if (!w[dpcw_pkg::CMD_START]) begin
            stop_of = dpcw_pkg::DPCW_STOP_RAMP;
        end else begin
            stop_of = dpcw_pkg::DPCW_STOP_NONE;
        end
    endfunction

    dpcw_pkg::dpcw_stop_t stop_raw;
    dpcw_pkg::dpcw_stop_t stop_eff;
    logic                 frozen;
    logic                 rev_bus;

    assign stop_raw = stop_of(word_reg);
    assign frozen   = !word_reg[dpcw_pkg::CMD_USE_RAMP];

    always_comb begin
        stop_eff = stop_raw;
        // ramp and quick stops cannot break a frozen frequency
        if (frozen && (stop_raw == dpcw_pkg::DPCW_STOP_QUICK
                       || stop_raw == dpcw_pkg::DPCW_STOP_RAMP)) begin
            stop_eff = dpcw_pkg::DPCW_STOP_NONE;
        end
    end

    always_comb begin
        case (cfg.rev_src)
            dpcw_pkg::REV_SRC_BUS: rev_bus = word_reg[dpcw_pkg::CMD_REVERSE];
            dpcw_pkg::REV_SRC_OR:  rev_bus = word_reg[dpcw_pkg::CMD_REVERSE] | din_reverse;
            dpcw_pkg::REV_SRC_AND: rev_bus = word_reg[dpcw_pkg::CMD_REVERSE] & din_reverse;
            default:               rev_bus = din_reverse;
        endcase
    end

    // ==========================================
    // decoded command outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg.preset_sel    <= word_reg[dpcw_pkg::CMD_PRESET_MSB:
                                              dpcw_pkg::CMD_PRESET_LSB];
            cmd_reg.stop_mode     <= stop_eff;
            cmd_reg.output_enable <= word_reg[dpcw_pkg::CMD_NO_COAST];
            cmd_reg.freeze        <= frozen;
            cmd_reg.jog           <= word_reg[dpcw_pkg::CMD_JOG];
            cmd_reg.ramp2         <= word_reg[dpcw_pkg::CMD_RAMP2];
            cmd_reg.relay1        <= word_reg[dpcw_pkg::CMD_RELAY1]
                                     && cfg.relay1_func == dpcw_pkg::RELAY1_OPT;
            cmd_reg.relay2        <= word_reg[dpcw_pkg::CMD_RELAY2]
                                     && cfg.relay2_func == dpcw_pkg::RELAY2_OPT;
            if (cfg.active_setup == dpcw_pkg::SETUP_MULTI_OPT) begin
                cmd_reg.setup2 <= word_reg[dpcw_pkg::CMD_SETUP2];
            end
            cmd_reg.reverse       <= rev_bus;
            cmd_reg.trip_reset    <= word_reg[dpcw_pkg::CMD_RESET] && !reset_bit_reg;
        end
    end

    // ==========================================
    // reset edge memory and frozen-mode side effects
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reset_bit_reg <= 1'b0;
        end else begin
            reset_bit_reg <= word_reg[dpcw_pkg::CMD_RESET];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_accepted_reg  <= 1'b0;
            freq_step_up_reg   <= 1'b0;
            freq_step_down_reg <= 1'b0;
        end else begin
            stop_accepted_reg  <= (stop_eff != dpcw_pkg::DPCW_STOP_NONE) || din_stop;
            // only the speed up/down inputs may nudge a frozen frequency
            freq_step_up_reg   <= frozen && din_speed_up && !din_speed_down;
            freq_step_down_reg <= frozen && din_speed_down && !din_speed_up;
        end
    end

    // ==========================================
    // state word snapshot
    logic [15:0] state_next;

    always_comb begin
        state_next                            = dpcw_pkg::ST_RESET_VAL;
        state_next[dpcw_pkg::ST_CTRL_READY]   = flags.ctrl_ready && !flags.tripped;
        state_next[dpcw_pkg::ST_DRV_READY]    = flags.drv_ready;
        state_next[dpcw_pkg::ST_ENABLE]       = word_reg[dpcw_pkg::CMD_NO_COAST];
        state_next[dpcw_pkg::ST_TRIP]         = flags.tripped;
        state_next[dpcw_pkg::ST_ERROR]        = flags.error;
        state_next[dpcw_pkg::ST_TRIPLOCK]     = flags.triplock;
        state_next[dpcw_pkg::ST_WARNING]      = flags.warning;
        state_next[dpcw_pkg::ST_AT_REF]       = flags.at_ref;
        state_next[dpcw_pkg::ST_BUS_CTRL]     = flags.bus_ctrl;
        state_next[dpcw_pkg::ST_FREQ_OK]      = flags.freq_ok;
        state_next[dpcw_pkg::ST_IN_OP]        = flags.running
                                                && word_reg[dpcw_pkg::CMD_NO_COAST];
        state_next[dpcw_pkg::ST_AUTO_START]   = flags.auto_stop;
        state_next[dpcw_pkg::ST_VOLT_EXC]     = flags.volt_exc;
        state_next[dpcw_pkg::ST_CURR_EXC]     = flags.curr_exc;
        state_next[dpcw_pkg::ST_THERM_EXC]    = flags.therm_exc;
        // bit 5 stays at its reset value of zero
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_state_word             <= dpcw_pkg::ST_RESET_VAL;
            actual_output_frequency_word <= 16'sh0000;
        end else begin
            drive_state_word             <= state_next;
            actual_output_frequency_word <= actual_freq_in;
        end
    end

    // ==========================================
    // checks
    sequence s_valid_write;
        cmd_wr && drive_command_word[dpcw_pkg::CMD_VALID];
    endsequence

    property p_ignore_invalid;
        @(posedge core_clk) disable iff (rst)
        (cmd_wr && !drive_command_word[dpcw_pkg::CMD_VALID]) |=> $stable(word_reg);
    endproperty
    a_ignore_invalid: assert property (p_ignore_invalid) else $error("invalid word used");

    property p_preset;
        @(posedge core_clk) disable iff (rst)
        s_valid_write |=> ##1 (cmd_reg.preset_sel == $past(drive_command_word[1:0], 2));
    endproperty
    a_preset: assert property (p_preset) else $error("preset select wrong");

    property p_coast;
        @(posedge core_clk) disable iff (rst)
        !word_reg[dpcw_pkg::CMD_NO_COAST] |=>
            (cmd_reg.stop_mode == dpcw_pkg::DPCW_STOP_COAST) && !cmd_reg.output_enable;
    endproperty
    a_coast: assert property (p_coast) else $error("coast not commanded");

    property p_dcbrake;
        @(posedge core_clk) disable iff (rst)
        (word_reg[dpcw_pkg::CMD_NO_COAST] && !word_reg[dpcw_pkg::CMD_RAMP_EN])
            |=> cmd_reg.stop_mode == dpcw_pkg::DPCW_STOP_DCBRK;
    endproperty
    a_dcbrake: assert property (p_dcbrake) else $error("dc brake not commanded");

    property p_frozen_no_ramp_stop;
        @(posedge core_clk) disable iff (rst)
        frozen |=> (cmd_reg.stop_mode != dpcw_pkg::DPCW_STOP_QUICK)
                   && (cmd_reg.stop_mode != dpcw_pkg::DPCW_STOP_RAMP);
    endproperty
    a_frozen_no_ramp_stop: assert property (p_frozen_no_ramp_stop)
        else $error("frozen stop");

    property p_reset_edge;
        @(posedge core_clk) disable iff (rst)
        cmd_reg.trip_reset |-> $past(word_reg[dpcw_pkg::CMD_RESET])
                               && !$past(word_reg[dpcw_pkg::CMD_RESET], 2);
    endproperty
    a_reset_edge: assert property (p_reset_edge) else $error("reset without edge");

    property p_reset_single;
        @(posedge core_clk) disable iff (rst)
        cmd_reg.trip_reset |=> !cmd_reg.trip_reset;
    endproperty
    a_reset_single: assert property (p_reset_single) else $error("reset repeated");

    property p_relay1;
        @(posedge core_clk) disable iff (rst)
        (cfg.relay1_func != dpcw_pkg::RELAY1_OPT) |=> !cmd_reg.relay1;
    endproperty
    a_relay1: assert property (p_relay1) else $error("relay 1 without option");

    property p_setup_hold;
        @(posedge core_clk) disable iff (rst)
        (cfg.active_setup != dpcw_pkg::SETUP_MULTI_OPT) |=> $stable(cmd_reg.setup2);
    endproperty
    a_setup_hold: assert property (p_setup_hold) else $error("set-up changed");

    property p_rev_digital;
        @(posedge core_clk) disable iff (rst)
        (cfg.rev_src == dpcw_pkg::REV_SRC_DIGITAL) |=> cmd_reg.reverse == $past(din_reverse);
    endproperty
    a_rev_digital: assert property (p_rev_digital) else $error("reverse source wrong");

    property p_ctrl_ready;
        @(posedge core_clk) disable iff (rst)
        flags.tripped |=> !drive_state_word[dpcw_pkg::ST_CTRL_READY]
                          && drive_state_word[dpcw_pkg::ST_TRIP];
    endproperty
    a_ctrl_ready: assert property (p_ctrl_ready) else $error("trip not reported");

    property p_bit5;
        @(posedge core_clk) disable iff (rst)
        1'b1 |-> !drive_state_word[5];
    endproperty
    a_bit5: assert property (p_bit5) else $error("state bit 5 set");

    property p_warning;
        @(posedge core_clk) disable iff (rst)
        flags.warning |=> drive_state_word[dpcw_pkg::ST_WARNING];
    endproperty
    a_warning: assert property (p_warning) else $error("warning missed");

    property p_limits;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[15:13]
                 == $past({flags.therm_exc, flags.curr_exc, flags.volt_exc});
    endproperty
    a_limits: assert property (p_limits) else $error("limit flags wrong");

    property p_quick_stop;
        @(posedge core_clk) disable iff (rst)
        (word_reg[dpcw_pkg::CMD_NO_COAST] && word_reg[dpcw_pkg::CMD_RAMP_EN]
         && !word_reg[dpcw_pkg::CMD_NO_QSTOP] && word_reg[dpcw_pkg::CMD_USE_RAMP])
            |=> cmd_reg.stop_mode == dpcw_pkg::DPCW_STOP_QUICK;
    endproperty
    a_quick_stop: assert property (p_quick_stop) else $error("quick stop missed");

    property p_ramp_stop;
        @(posedge core_clk) disable iff (rst)
        (word_reg[dpcw_pkg::CMD_NO_COAST] && word_reg[dpcw_pkg::CMD_RAMP_EN]
         && word_reg[dpcw_pkg::CMD_NO_QSTOP] && word_reg[dpcw_pkg::CMD_USE_RAMP]
         && !word_reg[dpcw_pkg::CMD_START]) |=> cmd_reg.stop_mode == dpcw_pkg::DPCW_STOP_RAMP;
    endproperty
    a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop missed");

    property p_freeze_step;
        @(posedge core_clk) disable iff (rst)
        (!word_reg[dpcw_pkg::CMD_USE_RAMP] && din_speed_up && !din_speed_down)
            |=> cmd_reg.freeze && freq_step_up_reg;
    endproperty
    a_freeze_step: assert property (p_freeze_step) else $error("frozen step missed");

    property p_run_no_step;
        @(posedge core_clk) disable iff (rst)
        word_reg[dpcw_pkg::CMD_USE_RAMP] |=> !freq_step_up_reg && !freq_step_down_reg;
    endproperty
    a_run_no_step: assert property (p_run_no_step) else $error("step not frozen");

    property p_ramp_set;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> cmd_reg.ramp2 == $past(word_reg[dpcw_pkg::CMD_RAMP2]);
    endproperty
    a_ramp_set: assert property (p_ramp_set) else $error("ramp set wrong");

    property p_relay2;
        @(posedge core_clk) disable iff (rst)
        (cfg.relay2_func != dpcw_pkg::RELAY2_OPT) |=> !cmd_reg.relay2;
    endproperty
    a_relay2: assert property (p_relay2) else $error("relay 2 without option");

    property p_setup_follow;
        @(posedge core_clk) disable iff (rst)
        (cfg.active_setup == dpcw_pkg::SETUP_MULTI_OPT)
            |=> cmd_reg.setup2 == $past(word_reg[dpcw_pkg::CMD_SETUP2]);
    endproperty
    a_setup_follow: assert property (p_setup_follow) else $error("set-up not taken");

    property p_rev_bus;
        @(posedge core_clk) disable iff (rst)
        (cfg.rev_src == dpcw_pkg::REV_SRC_BUS)
            |=> cmd_reg.reverse == $past(word_reg[dpcw_pkg::CMD_REVERSE]);
    endproperty
    a_rev_bus: assert property (p_rev_bus) else $error("bus reverse missed");

    property p_speed_ref;
        @(posedge core_clk) disable iff (rst)
        s_valid_write |=> speed_ref_reg == $past(speed_ref_word);
    endproperty
    a_speed_ref: assert property (p_speed_ref) else $error("speed reference lost");
endmodule

// file: dv/dpcw_master.sv
// bus master model writing command words and speed references to the block
// assumes calls start one ns after a rising edge of core_clk
module dpcw_master (
    input  wire logic          core_clk,
    output logic               cmd_wr,
    output logic [15:0]        drive_command_word,
    output logic signed [15:0] speed_ref_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // idle levels
    initial begin
        cmd_wr = 1'b0;
        drive_command_word = 16'h0000;
        speed_ref_word = 16'sh0000;
    end
    // ==========================================
    // one-cycle write strobe
    // released lines show the inverse so stale data of a valid word never looks valid
    task automatic send(input logic [15:0] word, input logic signed [15:0] ref_val);
        cmd_wr = 1'b1;
        drive_command_word = word;
        speed_ref_word = ref_val;
        @(posedge core_clk);
        #1;
        cmd_wr = 1'b0;
        drive_command_word = ~word;
        speed_ref_word = ~ref_val;
    endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the command/state word block
// assumes the block answers one edge after the edge that takes a word
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] word; logic [7:0] r1; logic [7:0] r2; logic [3:0] setup;
        logic [1:0] rev; logic din_rev; dpcw_pkg::dpcw_stop_t stop;
    } dpcw_row_t;
    logic core_clk, rst, cmd_wr, din_stop, din_reverse, din_speed_up, din_speed_down;
    logic stop_accepted_reg, freq_step_up_reg, freq_step_down_reg, exp_setup2, last_bit7;
    logic [15:0] drive_command_word, drive_state_word, cur_word;
    logic signed [15:0] speed_ref_word, actual_freq_in, actual_output_frequency_word;
    logic signed [15:0] speed_ref_reg;
    dpcw_pkg::dpcw_cfg_t   cfg;
    dpcw_pkg::dpcw_flags_t flags;
    dpcw_pkg::dpcw_cmd_t   cmd_reg, held;
    int failures = 0;
    int cmp_count = 0;
    logic [13:0] fpat [5] = '{14'h3FFF, 14'h2AAA, 14'h1555, 14'h2000, 14'h0000};
    dpcw_row_t rows [13] = '{
        '{16'h0400, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_COAST},
        '{16'h0408, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_DCBRK},
        '{16'h043C, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_RAMP},
        '{16'h042C, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_QUICK},
        '{16'h040C, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_NONE},
        '{16'h0404, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_COAST},
        '{16'h1F7E, 8'h24, 8'h25, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_NONE},
        '{16'h1F7D, 8'h25, 8'h24, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_NONE},
        '{16'hE47F, 8'h00, 8'h00, 4'h9, 2'h1, 1'b0, dpcw_pkg::DPCW_STOP_NONE},
        '{16'h847F, 8'h00, 8'h00, 4'h1, 2'h0, 1'b1, dpcw_pkg::DPCW_STOP_NONE},
        '{16'h847F, 8'h00, 8'h00, 4'h9, 2'h2, 1'b0, dpcw_pkg::DPCW_STOP_NONE},
        '{16'h047F, 8'h00, 8'h00, 4'h9, 2'h3, 1'b1, dpcw_pkg::DPCW_STOP_NONE},
        '{16'h04FF, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0, dpcw_pkg::DPCW_STOP_NONE}};

    dpcw_master mst (.core_clk(core_clk), .cmd_wr(cmd_wr),
        .drive_command_word(drive_command_word), .speed_ref_word(speed_ref_word));
    dpcw_core dut (.core_clk(core_clk), .rst(rst), .cmd_wr(cmd_wr),
        .drive_command_word(drive_command_word), .speed_ref_word(speed_ref_word),
        .cfg(cfg), .flags(flags), .din_stop(din_stop), .din_reverse(din_reverse),
        .din_speed_up(din_speed_up), .din_speed_down(din_speed_down),
        .actual_freq_in(actual_freq_in), .drive_state_word(drive_state_word),
        .actual_output_frequency_word(actual_output_frequency_word),
        .speed_ref_reg(speed_ref_reg), .cmd_reg(cmd_reg),
        .stop_accepted_reg(stop_accepted_reg), .freq_step_up_reg(freq_step_up_reg),
        .freq_step_down_reg(freq_step_down_reg));

    // ==========================================
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
    // ==========================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // expected fields worked out here, not read back from the block
    task automatic apply(input logic [15:0] w, input dpcw_pkg::dpcw_stop_t st);
        dpcw_pkg::dpcw_cmd_t e;
        logic rv;
        case (cfg.rev_src)
            dpcw_pkg::REV_SRC_BUS: rv = w[15];
            dpcw_pkg::REV_SRC_OR:  rv = w[15] | din_reverse;
            dpcw_pkg::REV_SRC_AND: rv = w[15] & din_reverse;
            default:               rv = din_reverse;
        endcase
        if (cfg.active_setup == dpcw_pkg::SETUP_MULTI_OPT) exp_setup2 = w[13];
        e = '{w[1:0], st, w[3], ~w[5], w[8], w[9],
              w[11] & (cfg.relay1_func == dpcw_pkg::RELAY1_OPT),
              w[12] & (cfg.relay2_func == dpcw_pkg::RELAY2_OPT), exp_setup2, rv,
              w[7] & ~last_bit7};
        last_bit7 = w[7];
        cur_word = w;
        mst.send(w, $signed(w));
        // the reset pulse stands only in the first cycle after the take
        tick(1);
        chk(16'(cmd_reg[13:9]), 16'(e[13:9]));
        chk(16'(cmd_reg[8:0]), 16'(e[8:0]));
        chk(16'(drive_state_word[dpcw_pkg::ST_ENABLE]), 16'(w[3]));
        tick(1);
        chk(16'(cmd_reg.trip_reset), 16'h0000);
        chk(16'(stop_accepted_reg), 16'((st != dpcw_pkg::DPCW_STOP_NONE) | din_stop));
        chk(speed_ref_reg, w);
    endtask
    task automatic state_chk(input dpcw_pkg::dpcw_flags_t f);
        logic [15:0] e;
        flags = f;
        e = {f.therm_exc, f.curr_exc, f.volt_exc, f.auto_stop, f.running & cur_word[3],
             f.freq_ok, f.bus_ctrl, f.at_ref, f.warning, f.triplock, 1'b0, f.error, f.tripped,
             cur_word[3], f.drv_ready, f.ctrl_ready & ~f.tripped};
        tick(1);
        chk(drive_state_word, e);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        tick(16);
        rst = 1'b0;
        exp_setup2 = 1'b0;
        last_bit7 = 1'b0;
        cur_word = 16'h0000;
        chk(drive_state_word, 16'h0000);
        chk(16'(cmd_reg), 16'h0000);
    endtask
    // ==========================================
    // main sequence
    initial begin
        {din_stop, din_reverse, din_speed_up, din_speed_down} = 4'h0;
        cfg = '0;
        flags = '0;
        actual_freq_in = 16'sh0000;
        do_reset();
        foreach (rows[i]) begin
            cfg = '{rows[i].r1, rows[i].r2, rows[i].setup, rows[i].rev};
            din_reverse = rows[i].din_rev;
            apply(rows[i].word, rows[i].stop);
        end
        // steady high reset bit must not pulse again
        apply(16'h04FF, dpcw_pkg::DPCW_STOP_NONE);
        held = cmd_reg;
        mst.send(16'h0377, 16'sh0377);
        tick(3);
        chk(16'(cmd_reg), 16'(held));
        chk(speed_ref_reg, 16'h04FF);
        apply(16'h047F, dpcw_pkg::DPCW_STOP_NONE);
        apply(16'h04FF, dpcw_pkg::DPCW_STOP_NONE);
        // frozen output: speed inputs step, stops limited
        apply(16'h040C, dpcw_pkg::DPCW_STOP_NONE);
        din_speed_up = 1'b1;
        tick(2);
        chk(16'({freq_step_up_reg, freq_step_down_reg}), 16'h0002);
        din_speed_down = 1'b1;
        tick(2);
        chk(16'({freq_step_up_reg, freq_step_down_reg}), 16'h0000);
        din_speed_up = 1'b0;
        tick(2);
        chk(16'({freq_step_up_reg, freq_step_down_reg}), 16'h0001);
        din_stop = 1'b1;
        tick(2);
        chk(16'(stop_accepted_reg), 16'h0001);
        apply(16'h047C, dpcw_pkg::DPCW_STOP_NONE);
        chk(16'({freq_step_up_reg, freq_step_down_reg}), 16'h0000);
        din_stop = 1'b0;
        actual_freq_in = 16'shC000;
        tick(1);
        chk(actual_output_frequency_word, 16'hC000);
        foreach (fpat[i]) state_chk(fpat[i]);
        apply(16'h0400, dpcw_pkg::DPCW_STOP_COAST);
        state_chk(14'h3FFF);
        do_reset();
        tally_and_finish();
    end
endmodule
